// ==== common/ckg_defs.vh ====
// Register map, field positions, reset values and bus states of the clock generator control bank.
// Included by the control bank module; holds definitions only.
`ifndef CKG_DEFS_VH
`define CKG_DEFS_VH

`define CKG_CMD_PD_MODE      8'h05
`define CKG_CMD_TEST_STOP    8'h06
`define CKG_CMD_IDENTITY     8'h07
`define CKG_CMD_REQ_ASSIGN   8'h08

`define CKG_PD_MODE_RESET    8'h00
`define CKG_REQ_ASSIGN_RESET 8'h40
// Writable bits of the test/stop byte: select, mode, strength, soft stop
`define CKG_TEST_STOP_WMASK  8'hD8
`define CKG_TEST_STOP_RESET  8'h18

`define CKG_BIT_CPU1_PD      1
`define CKG_BIT_CPU0_PD      0
`define CKG_BIT_TEST_SEL     7
`define CKG_BIT_TEST_MODE    6
`define CKG_BIT_REF_STRONG   4
`define CKG_BIT_SOFT_STOP    3
`define CKG_BIT_STRAP_C      2
`define CKG_BIT_STRAP_B      1
`define CKG_BIT_STRAP_A      0
// First of the four request-assignment bits: pairs 1, 3, 5, 7 in bits 4..7
`define CKG_BIT_REQ_LOW      4

`define CKG_ST_IDLE          3'h0
`define CKG_ST_ADDR          3'h1
`define CKG_ST_CMD           3'h2
`define CKG_ST_WDATA         3'h3
`define CKG_ST_ACK           3'h4
`define CKG_ST_RDATA         3'h5
`define CKG_ST_RACK          3'h6

`define CKG_PH_ADDR          2'h0
`define CKG_PH_CMD           2'h1
`define CKG_PH_DATA          2'h2

`endif

// ==== dv/ckg_ctrl_regs_bench.sv ====
// Bench for the control bank: register access over the management bus and output gating.
// Drives every pin from the bench; straps latched when power_good_n falls.
`timescale 1ns/1ns
module ckg_ctrl_regs_bench;
  reg        clock, rst_n, power_down_input, bus_clock_stop_n, clock_request_b_n, power_good_n;
  reg  [2:0] strap;
  reg  [5:0] stop_enable;
  reg  [1:0] ph = 2'b00;
  reg  [7:0] q;
  reg        nak;
  wire       smb_clk, smb_data, smb_data_oe, test_mode_active, test_ref_drive, ref_drive_high;
  wire [5:0] out_run;
  wire [1:0] cpu_pair_drive;
  int        err_total, compares, cycles;
  ckg_ctrl_regs #(.REV_CODE(4'h1), .VENDOR_ID(4'h5)) ckg_ctrl_regs_i (
    .clock(clock), .rst_n(rst_n), .smb_clk(smb_clk), .smb_data_in(smb_data), .smb_data_out(),
    .smb_data_oe(smb_data_oe), .power_down_input(power_down_input), .bus_clock_stop_n(bus_clock_stop_n),
    .clock_request_b_n(clock_request_b_n), .power_good_n(power_good_n), .freq_strap_a(strap[0]),
    .freq_strap_b(strap[1]), .freq_strap_c(strap[2]), .stop_enable(stop_enable), .out_phase({6{ph[1]}}),
    .out_run(out_run), .cpu_pair_drive(cpu_pair_drive), .test_mode_active(test_mode_active),
    .test_ref_drive(test_ref_drive), .ref_drive_high(ref_drive_high));
  ckg_smb_host ckg_smb_host_i (.clock(clock), .dev_oe(smb_data_oe), .smb_clk(smb_clk), .smb_data(smb_data));
  task finish_test;
    $display("counts: mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] c, input logic [7:0] d);
    ckg_smb_host_i.write_reg(c, d, nak); chk({7'h00, nak}, 8'h00);
  endtask
  task rdc(input logic [7:0] c, input logic [7:0] e);
    ckg_smb_host_i.read_reg(c, q, nak); chk({7'h00, nak}, 8'h00); chk(q, e);
  endtask
  // Three clocks of latency plus up to two of high phase
  task run_is(input logic [5:0] e); repeat (8) @(posedge clock); chk({2'b00, out_run}, {2'b00, e}); endtask
  task outs_are(input logic [4:0] e);
    repeat (8) @(posedge clock);
    chk({3'h0, cpu_pair_drive, test_mode_active, test_ref_drive, ref_drive_high}, {3'h0, e});
  endtask
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    ph <= ph + 2'b01;
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      finish_test;
    end
  end
  initial begin
    rst_n = 1'b0; power_down_input = 1'b0; bus_clock_stop_n = 1'b1; clock_request_b_n = 1'b0;
    power_good_n = 1'b1; strap = 3'b101; stop_enable = 6'h00;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    power_good_n <= 1'b0;
    repeat (8) @(posedge clock);
    strap <= 3'b010;
    outs_are(5'b11001);
    rdc(8'h05, 8'h00);
    rdc(8'h06, 8'h1D);
    rdc(8'h07, 8'h15);
    rdc(8'h08, 8'h40);
    $display("test reset done");
    power_down_input <= 1'b1;
    wr(8'h05, 8'h02);
    outs_are(5'b01001);
    wr(8'h05, 8'h01);
    outs_are(5'b10001);
    rdc(8'h05, 8'h01);
    power_down_input <= 1'b0;
    outs_are(5'b11001);
    $display("test power down done");
    wr(8'h06, 8'hFF);
    rdc(8'h06, 8'hDD);
    outs_are(5'b11111);
    wr(8'h06, 8'h40);
    outs_are(5'b11100);
    run_is(6'h3F);
    wr(8'h07, 8'h00);
    rdc(8'h07, 8'h15);
    rdc(8'h0A, 8'h00);
    wr(8'h06, 8'h18);
    $display("test mode byte done");
    stop_enable <= 6'b010101;
    wr(8'h06, 8'h10);
    run_is(6'b101010);
    wr(8'h06, 8'h18);
    run_is(6'h3F);
    stop_enable <= 6'b110000;
    bus_clock_stop_n <= 1'b0;
    run_is(6'b001111);
    bus_clock_stop_n <= 1'b1;
    stop_enable <= 6'h00;
    $display("test stop done");
    clock_request_b_n <= 1'b1;
    run_is(6'b111011);
    wr(8'h08, 8'hB0);
    run_is(6'b110100);
    rdc(8'h08, 8'hB0);
    clock_request_b_n <= 1'b0;
    run_is(6'h3F);
    $display("test request pin done");
    finish_test;
  end
endmodule // ckg_ctrl_regs_bench

// ==== dv/ckg_ctrl_regs_sva.sv ====
// Port checks for the clock generator control bank.
// Assumes a bus host keeping half periods of at least 4 clocks.
`timescale 1ns/1ns
module ckg_ctrl_regs_sva #(
  parameter NUM_OUT = 6
) (
  input wire               clock,
  input wire               rst_n,
  input wire               smb_clk,
  input wire               smb_data_oe,
  input wire               smb_data_out,
  input wire               power_down_input,
  input wire               bus_clock_stop_n,
  input wire [NUM_OUT-1:0] stop_enable,
  input wire [NUM_OUT-1:0] out_phase,
  input wire [NUM_OUT-1:0] out_run,
  input wire [1:0]         cpu_pair_drive,
  input wire               test_mode_active,
  input wire               test_ref_drive,
  input wire               ref_drive_high
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_gate_when_low: assert property (((out_run ^ $past(out_run)) & $past(out_phase)) == '0)
    else $error("out_run moved while output high");
  chk_free_keeps_run: assert property (!stop_enable[5] && !out_phase[5] |=> out_run[5])
    else $error("free running output stopped");
  chk_hw_stop_halts: assert property ((!bus_clock_stop_n && stop_enable[5]) [*4] ##0 !out_phase[5] |=> !out_run[5])
    else $error("stoppable output kept running");
  chk_drive_no_pd: assert property (!power_down_input [*4] |=> cpu_pair_drive == 2'b11)
    else $error("cpu pair released outside power down");
  chk_ref_in_test: assert property (test_ref_drive |-> test_mode_active)
    else $error("reference drive outside test mode");
  // Open drain: the data output must never drive a high level onto the wire
  chk_data_out_low: assert property (!smb_data_out)
    else $error("data output not held low");
  chk_bus_edge_low: assert property ($changed(smb_data_oe) |-> !smb_clk)
    else $error("data pin moved while bus clock high");
  chk_reset_ref_high: assert property ($rose(rst_n) |-> ref_drive_high)
    else $error("reference strength low after reset");
  chk_reset_normal: assert property ($rose(rst_n) |-> !test_mode_active && !test_ref_drive)
    else $error("test mode active after reset");
  cov_stop: cover property ($fell(out_run[0]));
  cov_test_ref: cover property ($rose(test_ref_drive));
  cov_pd_tri: cover property (cpu_pair_drive == 2'b01);
endmodule // ckg_ctrl_regs_sva

bind ckg_ctrl_regs ckg_ctrl_regs_sva #(.NUM_OUT(NUM_OUT)) ckg_ctrl_regs_sva_i (
  .clock(clock), .rst_n(rst_n), .smb_clk(smb_clk), .smb_data_oe(smb_data_oe), .smb_data_out(smb_data_out),
  .power_down_input(power_down_input), .bus_clock_stop_n(bus_clock_stop_n), .stop_enable(stop_enable),
  .out_phase(out_phase), .out_run(out_run), .cpu_pair_drive(cpu_pair_drive),
  .test_mode_active(test_mode_active), .test_ref_drive(test_ref_drive), .ref_drive_high(ref_drive_high));

// ==== dv/ckg_smb_host.sv ====
// Management bus host: byte write and byte read by command code.
// Data line has a pull-up; the device pulls it low through dev_oe.
`timescale 1ns/1ns
module ckg_smb_host #(
  parameter [6:0] ADDR = 7'h69
) (
  input  wire clock,
  input  wire dev_oe,
  output reg  smb_clk,
  output wire smb_data
);
  reg sda = 1'b1;
  assign smb_data = sda & ~dev_oe;
  initial smb_clk = 1'b1;
  // Ten clocks per half period, well above the four the device needs
  task hold; repeat (5) @(posedge clock); endtask
  task bit_io(input logic b, output logic r);
    smb_clk <= 1'b0; hold; sda <= b; hold; smb_clk <= 1'b1; hold; r = smb_data; hold;
  endtask
  task xfer(input logic [7:0] d, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(1'b1, a);
  endtask
  task stop; smb_clk <= 1'b0; hold; sda <= 1'b0; hold; smb_clk <= 1'b1; hold; sda <= 1'b1; hold; endtask
  task write_reg(input logic [7:0] c, input logic [7:0] d, output logic nak);
    logic [7:0] q; logic a0, a1, a2;
    sda <= 1'b0; hold; xfer({ADDR, 1'b0}, q, a0); xfer(c, q, a1); xfer(d, q, a2); stop;
    nak = a0 | a1 | a2;
  endtask
  task read_reg(input logic [7:0] c, output logic [7:0] d, output logic nak);
    logic [7:0] q; logic a0, a1, a2, a3;
    sda <= 1'b0; hold; xfer({ADDR, 1'b0}, q, a0); xfer(c, q, a1);
    smb_clk <= 1'b0; hold; sda <= 1'b1; hold; smb_clk <= 1'b1; hold; sda <= 1'b0; hold;
    xfer({ADDR, 1'b1}, q, a2); xfer(8'hFF, d, a3); stop;
    nak = a0 | a1 | a2;
  endtask
endmodule // ckg_smb_host

// ==== rtl/ckg_ctrl_regs.v ====
// Control bytes 5 to 8 of a clock generator, reached by the serial management bus,
// with power-down drive choice, test mode, soft bus-clock stop, strap readback and request-pin assignment.
// Assumes all pins are asynchronous to clock and that out_phase comes from logic on clock.
//
// Function
// - CPU pair 1 driven in power-down when bit is 0, tri-stated when 1; default 0.
// - CPU pair 0 driven in power-down when bit 0 is 0, tri-stated when 1; default 0.
// - Test/stop bit 6 enters test clock mode when 1; default normal operation.
// - In test mode bit 7 picks tri-state (0) or divided reference (1); default 0.
// - Test/stop bit 4 sets reference drive strength, 1 high; default high.
// - Soft stop bit written 0 halts stoppable bus and SRC clocks cleanly.
// - Soft stop bit written 1 restarts stopped outputs cleanly; default 1, not stopping.
// - Outputs configured free running ignore the soft stop and keep toggling.
// - Bits 2..0 read straps C, B, A caught when power good asserts.
// - Identity byte holds revision code high nibble and vendor code low nibble, read only.
// - Request bit 7 lets request pin B stop SRC pair 7; default 0.
// - Request bit 6 ties SRC pair 5 to request pin B; default 1.
// - Request bit 5 lets request pin B stop SRC pair 3; default 0.
// - Request bit 4 lets request pin B stop SRC pair 1; default 0.
// - Each output's own stop-enable bit decides free running or stoppable.
`timescale 1ns/1ns
`include "ckg_defs.vh"

module ckg_ctrl_regs #(
  parameter [6:0] BUS_ADDR  = 7'h69,
  // Arbitrary values, not tied to any maker
  parameter [3:0] REV_CODE  = 4'h1,
  parameter [3:0] VENDOR_ID = 4'h5,
  parameter       NUM_OUT   = 6
) (
  input  wire               clock,
  input  wire               rst_n,
  input  wire               smb_clk,
  input  wire               smb_data_in,
  output reg                smb_data_out,
  output reg                smb_data_oe,
  input  wire               power_down_input,
  input  wire               bus_clock_stop_n,
  input  wire               clock_request_b_n,
  input  wire               power_good_n,
  input  wire               freq_strap_a,
  input  wire               freq_strap_b,
  input  wire               freq_strap_c,
  input  wire [NUM_OUT-1:0] stop_enable,
  input  wire [NUM_OUT-1:0] out_phase,
  output reg  [NUM_OUT-1:0] out_run,
  output reg  [1:0]         cpu_pair_drive,
  output reg                test_mode_active,
  output reg                test_ref_drive,
  output reg                ref_drive_high
);

  // Pin synchronisers: first stage feeds only the second
  reg [6:0] sync_a;
  reg [6:0] sync_b;
  reg       scl_prev;
  reg       sda_prev;
  wire [6:0] pins = {smb_clk, smb_data_in, power_down_input, bus_clock_stop_n,
                     clock_request_b_n, power_good_n, 1'b0};

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_a   <= 7'h7F;
      sync_b   <= 7'h7F;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      sync_a   <= pins;
      sync_b   <= sync_a;
      scl_prev <= sync_b[6];
      sda_prev <= sync_b[5];
    end
  end

  wire scl_s      = sync_b[6];
  wire sda_s      = sync_b[5];
  wire pd_s       = sync_b[4];
  wire hw_stop_n  = sync_b[3];
  wire req_b_n    = sync_b[2];
  wire pgood_n_s  = sync_b[1];
  wire scl_rise   = scl_s & ~scl_prev;
  wire scl_fall   = ~scl_s & scl_prev;
  wire bus_start  = scl_s & scl_prev & sda_prev & ~sda_s;
  wire bus_stop   = scl_s & scl_prev & ~sda_prev & sda_s;

  // Straps move slowly but still pass two flops before capture
  reg [2:0] strap_a;
  reg [2:0] strap_b;
  reg [2:0] strap_val;
  reg       pgood_seen;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_a    <= 3'h0;
      strap_b    <= 3'h0;
      strap_val  <= 3'h0;
      pgood_seen <= 1'b0;
    end else begin
      strap_a    <= {freq_strap_c, freq_strap_b, freq_strap_a};
      strap_b    <= strap_a;
      pgood_seen <= ~pgood_n_s;
      if (!pgood_n_s && !pgood_seen)
        strap_val <= strap_b;
    end
  end

  // Register storage
  reg [7:0] pd_mode;
  reg [7:0] test_stop;
  reg [7:0] req_assign;
  reg [7:0] cmd;

  wire [7:0] identity = {REV_CODE, VENDOR_ID};

  reg [7:0] rd_byte;
  always @* begin
    case (cmd)
      `CKG_CMD_PD_MODE:    rd_byte = pd_mode;
      `CKG_CMD_TEST_STOP:  rd_byte = (test_stop & `CKG_TEST_STOP_WMASK) | {5'h00, strap_val};
      `CKG_CMD_IDENTITY:   rd_byte = identity;
      `CKG_CMD_REQ_ASSIGN: rd_byte = req_assign;
      default:             rd_byte = 8'h00;
    endcase
  end

  // Serial bus slave: byte write and byte read by command code
  reg [2:0] state;
  reg [1:0] phase;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg       rw_read;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state        <= `CKG_ST_IDLE;
      phase        <= `CKG_PH_ADDR;
      bit_cnt      <= 4'h0;
      shift        <= 8'h00;
      rw_read      <= 1'b0;
      cmd          <= 8'h00;
      smb_data_out <= 1'b0;
      smb_data_oe  <= 1'b0;
      pd_mode      <= `CKG_PD_MODE_RESET;
      test_stop    <= `CKG_TEST_STOP_RESET;
      req_assign   <= `CKG_REQ_ASSIGN_RESET;
    end else if (bus_stop) begin
      state       <= `CKG_ST_IDLE;
      smb_data_oe <= 1'b0;
    end else if (bus_start) begin
      state       <= `CKG_ST_ADDR;
      phase       <= `CKG_PH_ADDR;
      bit_cnt     <= 4'h0;
      smb_data_oe <= 1'b0;
    end else if (scl_rise) begin
      case (state)
        `CKG_ST_ADDR, `CKG_ST_CMD, `CKG_ST_WDATA: begin
          shift   <= {shift[6:0], sda_s};
          bit_cnt <= bit_cnt + 4'h1;
        end
        `CKG_ST_RACK: begin
          // Host NACK ends the read; ACK repeats the same byte
          if (sda_s)
            state <= `CKG_ST_IDLE;
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state)
        `CKG_ST_ADDR: begin
          if (bit_cnt == 4'h8) begin
            if (shift[7:1] == BUS_ADDR) begin
              rw_read     <= shift[0];
              state       <= `CKG_ST_ACK;
              smb_data_oe <= 1'b1;
            end else
              state <= `CKG_ST_IDLE;
          end
        end
        `CKG_ST_CMD, `CKG_ST_WDATA: begin
          if (bit_cnt == 4'h8) begin
            state       <= `CKG_ST_ACK;
            smb_data_oe <= 1'b1;
            if (state == `CKG_ST_CMD)
              cmd <= shift;
            else begin
              case (cmd)
                `CKG_CMD_PD_MODE:    pd_mode    <= shift;
                `CKG_CMD_TEST_STOP:  test_stop  <= shift & `CKG_TEST_STOP_WMASK;
                `CKG_CMD_REQ_ASSIGN: req_assign <= shift;
                default: ;
              endcase
            end
          end
        end
        `CKG_ST_ACK: begin
          bit_cnt <= 4'h0;
          if (phase == `CKG_PH_ADDR && rw_read) begin
            state       <= `CKG_ST_RDATA;
            shift       <= {rd_byte[6:0], 1'b0};
            smb_data_oe <= ~rd_byte[7];
            bit_cnt     <= 4'h1;
          end else begin
            smb_data_oe <= 1'b0;
            state       <= (phase == `CKG_PH_ADDR) ? `CKG_ST_CMD : `CKG_ST_WDATA;
            phase       <= (phase == `CKG_PH_ADDR) ? `CKG_PH_CMD : `CKG_PH_DATA;
          end
        end
        `CKG_ST_RDATA: begin
          if (bit_cnt == 4'h8) begin
            state       <= `CKG_ST_RACK;
            smb_data_oe <= 1'b0;
          end else begin
            smb_data_oe <= ~shift[7];
            shift       <= {shift[6:0], 1'b0};
            bit_cnt     <= bit_cnt + 4'h1;
          end
        end
        `CKG_ST_RACK: begin
          state       <= `CKG_ST_RDATA;
          shift       <= {rd_byte[6:0], 1'b0};
          smb_data_oe <= ~rd_byte[7];
          bit_cnt     <= 4'h1;
        end
        default: ;
      endcase
    end
  end

  // Output gating: channels 0..3 are SRC pairs 1,3,5,7; 4 and 5 bus clocks, each stoppable by its stop_enable bit
  wire       stop_req = ~test_stop[`CKG_BIT_SOFT_STOP] | ~hw_stop_n;
  wire [5:0] req_map  = {2'b00, req_assign[`CKG_BIT_REQ_LOW+3:`CKG_BIT_REQ_LOW]};

  genvar i;
  generate
    for (i = 0; i < NUM_OUT; i = i + 1) begin : g_gate
      // Free-running outputs never see the stop, only their request pin
      wire want_run = ~(stop_enable[i] & stop_req) & ~(req_map[i] & req_b_n);
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n)
          out_run[i] <= 1'b1;
        else if (!out_phase[i])
          out_run[i] <= want_run;
      end
    end
  endgenerate

  // Static controls from the registers, CPU pairs also gated by the power-down pin
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cpu_pair_drive   <= 2'b11;
      test_mode_active <= 1'b0;
      test_ref_drive   <= 1'b0;
      ref_drive_high   <= 1'b1;
    end else begin
      cpu_pair_drive[1] <= ~(pd_s & pd_mode[`CKG_BIT_CPU1_PD]);
      cpu_pair_drive[0] <= ~(pd_s & pd_mode[`CKG_BIT_CPU0_PD]);
      test_mode_active  <= test_stop[`CKG_BIT_TEST_MODE];
      test_ref_drive    <= test_stop[`CKG_BIT_TEST_MODE] & test_stop[`CKG_BIT_TEST_SEL];
      ref_drive_high    <= test_stop[`CKG_BIT_REF_STRONG];
    end
  end

endmodule // ckg_ctrl_regs
